/* File: compact_timer.sv */
/*
 Compact 10-bit timer: counter, two comparators, compare
 output, PWM output and byte-wide register port.
 Assumes a single 40 MHz clock; the high-speed clock, the sub
 clock and the count pin arrive asynchronously and are
 synchronised here.
*/
// Summary of operation
// - 10-bit up counter, two comparators.
// - Low write buffers; high write copies buffer.
// - High read captures low byte into buffer.
// - P checks top three bits; A all.
// - Counter cleared by counter-on rising and by a clearing match.
// - Overflow or match clears, raising request.
// - Pause holds count; release resumes.
// - Clock select picks one of seven sources; two of its eight codes pick the sub clock.
// - Counter-on low stops and holds count.
// - Counter-on rising loads initial output level.
// - P value n gives n times 128; zero gives 1024.
// - Clear-select low: P match clears counter; in PWM mode the swap bit picks the clearing match instead.
// - Mode field: compare, undefined, PWM, timer.
// - Compare match: hold, low, high, toggle.
// - PWM: inactive, active, waveform, undefined.
// - Timer mode leaves output pin unused.
// - Second pin is complement of first.
// - Initial level bit: start level, active level.
// - Clear-select high: A match clears counter; in PWM mode the swap bit picks the clearing match instead.
// - Polarity bit inverts both output pins.
// - Swap bit exchanges period and duty comparators.
`timescale 1ns/1ps
`include "compact_timer_defines.svh"

module compact_timer (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       high_clk_i,
    input  wire logic       sub_clk_i,
    input  wire logic       external_count_pin_i,
    output logic            timer_output_o,
    output logic            timer_output_inverted_o,
    output logic            timer_output_en_o,
    output logic            match_a_req_o,
    output logic            match_p_req_o
);
    import compact_timer_pkg::*;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    function automatic logic rise(input logic [2:0] s);
        rise = s[1] & ~s[2];
    endfunction

    logic [7:0] ctl0_r;
    logic [7:0] ctl1_r;
    logic [7:0] buf_r;
    logic [7:0] rdata_r;
    logic [9:0] cnt_r;
    logic [9:0] cmpa_r;
    logic       on_d_r;
    logic [2:0] hsync_r;
    logic [2:0] ssync_r;
    logic [2:0] esync_r;
    logic [1:0] pre4_r;
    logic [5:0] preh_r;
    logic       out_r;
    logic       pin_r;
    logic       pinb_r;
    logic       en_r;
    logic       reqa_r;
    logic       reqp_r;

    op_mode_t   mode;
    clk_sel_t   csel;
    pin_fn_t    fn;
    logic [2:0] compare_p_value;
    logic       on;
    logic       pau;
    logic       oc;
    logic       pol;
    logic       dpx;
    logic       cclr;
    logic       on_rise;
    logic       cmp_mode;
    logic       pwm_mode;
    logic       h_edge;
    logic       s_edge;
    logic       e_rise;
    logic       e_fall;
    logic       tick;
    logic       run;
    logic [9:0] cnt_inc;
    logic       a_hit;
    logic       p_hit;
    logic       clr;
    logic [9:0] duty;
    logic       pwm_act;
    logic       pwm_lvl;
    logic       pin_lvl;

    assign on       = ctl0_r[`CT_ON_BIT];
    assign pau      = ctl0_r[`CT_PAU_BIT];
    assign csel     = clk_sel_t'(ctl0_r[`CT_CK_MSB:`CT_CK_LSB]);
    assign compare_p_value     = ctl0_r[`CT_RP_MSB:`CT_RP_LSB];
    assign mode     = op_mode_t'(ctl1_r[`CT_MODE_MSB:`CT_MODE_LSB]);
    assign fn       = pin_fn_t'(ctl1_r[`CT_FN_MSB:`CT_FN_LSB]);
    assign oc       = ctl1_r[`CT_OC_BIT];
    assign pol      = ctl1_r[`CT_POL_BIT];
    assign dpx      = ctl1_r[`CT_DPX_BIT];
    assign cclr     = ctl1_r[`CT_CCLR_BIT];
    assign on_rise  = on & ~on_d_r;
    // The undefined mode code behaves as timer mode, pin unused.
    assign cmp_mode = (mode == MODE_CMP);
    assign pwm_mode = (mode == MODE_PWM);

    // Two flops synchronise, the third only serves edge finding.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hsync_r <= 3'h0;
            ssync_r <= 3'h0;
            esync_r <= 3'h0;
        end else begin
            hsync_r <= {hsync_r[1:0], high_clk_i};
            ssync_r <= {ssync_r[1:0], sub_clk_i};
            esync_r <= {esync_r[1:0], external_count_pin_i};
        end
    end

    assign h_edge = rise(hsync_r);
    assign s_edge = rise(ssync_r);
    assign e_rise = rise(esync_r);
    assign e_fall = rise(~esync_r);

    // Prescalers run freely so a source change needs no restart.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre4_r <= 2'h0;
            preh_r <= 6'h00;
        end else begin
            pre4_r <= pre4_r + 2'h1;
            if (h_edge) begin
                preh_r <= preh_r + 6'h01;
            end
        end
    end

    always_comb begin
        case (csel)
            CK_SYS4:  tick = (pre4_r == `CT_SYS4_LAST);
            CK_SYS:   tick = 1'b1;
            CK_H16:   tick = h_edge & (preh_r[3:0] == `CT_H16_LAST);
            CK_H64:   tick = h_edge & (preh_r == `CT_H64_LAST);
            CK_SUB0:  tick = s_edge;
            CK_SUB1:  tick = s_edge;
            CK_EXT_R: tick = e_rise;
            CK_EXT_F: tick = e_fall;
            default:  tick = 1'b0;
        endcase
    end

    assign run     = on & ~pau & tick;
    assign cnt_inc = cnt_r + 10'h001;
    // P value zero wraps to the 1024-count overflow.
    assign p_hit   = (cnt_r[6:0] == `CT_SEG_LAST) &&
                     (3'(cnt_r[9:7] + 3'h1) == compare_p_value);
    // A value zero never matches; the counter then overflows.
    assign a_hit   = (cmpa_r != `CT_VAL_RST) && (cnt_inc == cmpa_r);

    always_comb begin
        if (pwm_mode) begin
            clr = dpx ? a_hit : p_hit;
        end else begin
            clr = cclr ? a_hit : p_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_d_r <= 1'b0;
        end else begin
            on_d_r <= on;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= `CT_VAL_RST;
        end else if (on_rise) begin
            cnt_r <= `CT_VAL_RST;
        end else if (run) begin
            cnt_r <= clr ? `CT_VAL_RST : cnt_inc;
        end
    end

    // No P request while A clears the counter outside PWM.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reqa_r <= 1'b0;
            reqp_r <= 1'b0;
        end else begin
            reqa_r <= run & a_hit & ~on_rise;
            reqp_r <= run & p_hit & ~on_rise & (pwm_mode | ~cclr);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_r <= 1'b0;
        end else if (on_rise) begin
            out_r <= oc;
        end else if (run && a_hit && cmp_mode) begin
            case (fn)
                FN_01:   out_r <= 1'b0;
                FN_10:   out_r <= 1'b1;
                FN_11:   out_r <= ~out_r;
                default: out_r <= out_r;
            endcase
        end
    end

    assign duty    = dpx ? {compare_p_value, 7'h00} : cmpa_r;
    assign pwm_act = (cnt_r < duty);

    always_comb begin
        case (fn)
            FN_01:   pwm_lvl = oc;
            FN_10:   pwm_lvl = pwm_act ? oc : ~oc;
            default: pwm_lvl = ~oc;
        endcase
    end

    assign pin_lvl = pwm_mode ? pwm_lvl : out_r;

    // In timer mode the pins keep their last level, undriven.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_r  <= 1'b0;
            pinb_r <= 1'b1;
            en_r   <= 1'b0;
        end else begin
            en_r <= cmp_mode | pwm_mode;
            if (cmp_mode || pwm_mode) begin
                pin_r  <= pin_lvl ^ pol;
                pinb_r <= ~(pin_lvl ^ pol);
            end
        end
    end

    // Software order matters: the single buffer is shared by
    // both pairs, so an interleaved access corrupts the low byte.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl0_r <= `CT_CTL_RST;
            ctl1_r <= `CT_CTL_RST;
            cmpa_r <= `CT_VAL_RST;
            buf_r  <= `CT_BUF_RST;
        end else if (wr_i) begin
            case (addr_i)
                `CT_OFS_CTL0:   ctl0_r <= wdata_i;
                `CT_OFS_CTL1:   ctl1_r <= wdata_i;
                `CT_OFS_CMPA_L: buf_r <= wdata_i;
                `CT_OFS_CMPA_H: cmpa_r <= {wdata_i[1:0], buf_r};
                default:        buf_r <= buf_r;
            endcase
        end else if (rd_i) begin
            case (addr_i)
                `CT_OFS_CNT_H:  buf_r <= cnt_r[7:0];
                `CT_OFS_CMPA_H: buf_r <= cmpa_r[7:0];
                default:        buf_r <= buf_r;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `CT_OFS_CTL0:   rdata_r <= ctl0_r;
                `CT_OFS_CTL1:   rdata_r <= ctl1_r;
                `CT_OFS_CNT_L:  rdata_r <= buf_r;
                `CT_OFS_CNT_H:  rdata_r <= {6'h00, cnt_r[9:8]};
                `CT_OFS_CMPA_L: rdata_r <= buf_r;
                `CT_OFS_CMPA_H: rdata_r <= {6'h00, cmpa_r[9:8]};
                default:        rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata_o                 = rdata_r;
    assign timer_output_o          = pin_r;
    assign timer_output_inverted_o = pinb_r;
    assign timer_output_en_o       = en_r;
    assign match_a_req_o           = reqa_r;
    assign match_p_req_o           = reqp_r;

    property p_on_clear;
        on_rise |=> (cnt_r == `CT_VAL_RST);
    endproperty
    a_on_clear: assert property (p_on_clear)
        else $error("counter not cleared on enable");

    property p_pause_hold;
        (on && pau && !on_rise) |=> $stable(cnt_r);
    endproperty
    a_pause_hold: assert property (p_pause_hold)
        else $error("counter moved while paused");

    property p_off_hold;
        (!on && !on_d_r) |=> $stable(cnt_r);
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("counter moved while off");

    property p_compl;
        !rst_i |-> (timer_output_inverted_o == !timer_output_o);
    endproperty
    a_compl: assert property (p_compl)
        else $error("second pin not complement");

    property p_hi_write;
        (wr_i && addr_i == `CT_OFS_CMPA_H) |=>
            (cmpa_r == {$past(wdata_i[1:0]), $past(buf_r)});
    endproperty
    a_hi_write: assert property (p_hi_write)
        else $error("high write did not copy buffer");

    property p_lo_write;
        (wr_i && addr_i == `CT_OFS_CMPA_L) |=>
            ($stable(cmpa_r) && buf_r == $past(wdata_i));
    endproperty
    a_lo_write: assert property (p_lo_write)
        else $error("low write touched compare value");

    property p_hi_read;
        (rd_i && addr_i == `CT_OFS_CNT_H) |=>
            (buf_r == $past(cnt_r[7:0]) &&
             rdata_o == {6'h00, $past(cnt_r[9:8])});
    endproperty
    a_hi_read: assert property (p_hi_read)
        else $error("high read did not capture low byte");

    property p_p_clear;
        (run && p_hit && !pwm_mode && !cclr && !on_rise) |=>
            (cnt_r == `CT_VAL_RST && match_p_req_o) ##1
            (match_p_req_o == 1'b0);
    endproperty
    a_p_clear: assert property (p_p_clear)
        else $error("P match did not clear counter");

    property p_toggle;
        (run && a_hit && cmp_mode && fn == FN_11 && !on_rise) |=>
            (out_r != $past(out_r)) ##1
            (pin_r == ($past(out_r) ^ $past(pol)));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle did not happen");

    property p_init_lvl;
        on_rise |=> (out_r == $past(oc));
    endproperty
    a_init_lvl: assert property (p_init_lvl)
        else $error("initial level not loaded");

    property p_tmr_pin;
        (mode == MODE_TMR) |=> !timer_output_en_o;
    endproperty
    a_tmr_pin: assert property (p_tmr_pin)
        else $error("pin driven in timer mode");

    property p_req_a;
        (run && a_hit && !on_rise) |=> match_a_req_o;
    endproperty
    a_req_a: assert property (p_req_a)
        else $error("A request missing");

    c_a_clear: cover property (run && a_hit && cclr && cmp_mode);
    c_overflow: cover property (run && p_hit && compare_p_value == 3'h0);
    c_pwm_run: cover property (pwm_mode && fn == FN_10 && run);
    c_pause: cover property (on && pau ##1 on && !pau);
endmodule

/* File: compact_timer_defines.svh */
/*
 Register offsets, field positions, reset values and divider
 counts of the compact 10-bit timer.
 Assumes inclusion by bare name before the timer module.
*/
`ifndef COMPACT_TIMER_DEFINES_SVH
`define COMPACT_TIMER_DEFINES_SVH

`define CT_OFS_CTL0   3'h0
`define CT_OFS_CTL1   3'h1
`define CT_OFS_CNT_L  3'h2
`define CT_OFS_CNT_H  3'h3
`define CT_OFS_CMPA_L 3'h4
`define CT_OFS_CMPA_H 3'h5

`define CT_CTL_RST    8'h00
`define CT_VAL_RST    10'h000
`define CT_BUF_RST    8'h00

`define CT_PAU_BIT    7
`define CT_CK_MSB     6
`define CT_CK_LSB     4
`define CT_ON_BIT     3
`define CT_RP_MSB     2
`define CT_RP_LSB     0
`define CT_MODE_MSB   7
`define CT_MODE_LSB   6
`define CT_FN_MSB     5
`define CT_FN_LSB     4
`define CT_OC_BIT     3
`define CT_POL_BIT    2
`define CT_DPX_BIT    1
`define CT_CCLR_BIT   0

`define CT_SYS4_LAST  2'h3
`define CT_H16_LAST   4'hF
`define CT_H64_LAST   6'h3F
`define CT_SEG_LAST   7'h7F

`endif

/* File: compact_timer_pkg.sv */
/*
 Types of the compact 10-bit timer: operating modes, clock
 sources and pin functions.
 Assumes nothing of its surroundings.
*/
package compact_timer_pkg;
    typedef enum logic [1:0] {
        MODE_CMP   = 2'b00,
        MODE_UNDEF = 2'b01,
        MODE_PWM   = 2'b10,
        MODE_TMR   = 2'b11
    } op_mode_t;

    typedef enum logic [2:0] {
        CK_SYS4  = 3'b000,
        CK_SYS   = 3'b001,
        CK_H16   = 3'b010,
        CK_H64   = 3'b011,
        CK_SUB0  = 3'b100,
        CK_SUB1  = 3'b101,
        CK_EXT_R = 3'b110,
        CK_EXT_F = 3'b111
    } clk_sel_t;

    typedef enum logic [1:0] {
        FN_00 = 2'b00,
        FN_01 = 2'b01,
        FN_10 = 2'b10,
        FN_11 = 2'b11
    } pin_fn_t;
endpackage

/* File: timer_pins.sv */
/*
 Far-side model of the timer pins: free-running high and sub
 clocks and a count pin that the bench pulses on demand.
 Assumes the bench calls pulse while the timer is counting.
*/
`timescale 1ns/1ps
module timer_pins (
    output logic high_clk_o,
    output logic sub_clk_o,
    output logic count_pin_o
);
    initial begin
        high_clk_o = 1'b0;
        sub_clk_o = 1'b0;
        count_pin_o = 1'b0;
    end

    // Periods are not whole multiples of the bench clock period.
    always #55 high_clk_o = ~high_clk_o;
    always #15259 sub_clk_o = ~sub_clk_o;

    // Each level lasts many cycles so the synchroniser sees it.
    task automatic pulse(input int n);
        repeat (n) begin
            #200 count_pin_o = 1'b1;
            #200 count_pin_o = 1'b0;
        end
        #200;
    endtask
endmodule

/* File: compact_timer_bench.sv */
/*
 Self-checking bench of the compact timer.
 Assumes the far-side pin model and the register offsets header.
*/
`timescale 1ns/1ps
`include "compact_timer_defines.svh"
module compact_timer_bench;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic       hclk, sclk, cpin, out_o, outn_o, en_o, req_a, req_p;
    int         error_cnt = 0;
    int         n_checks = 0;

    always #12.5 clk_i = ~clk_i;

    compact_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .high_clk_i(hclk), .sub_clk_i(sclk), .external_count_pin_i(cpin),
        .timer_output_o(out_o), .timer_output_inverted_o(outn_o),
        .timer_output_en_o(en_o), .match_a_req_o(req_a),
        .match_p_req_o(req_p));

    timer_pins i_far (.high_clk_o(hclk), .sub_clk_o(sclk),
        .count_pin_o(cpin));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // High byte first, so both bytes come from one snapshot.
    task automatic rd_cnt(output logic [15:0] v);
        logic [7:0] h, l;
        rd(`CT_OFS_CNT_H, h);
        rd(`CT_OFS_CNT_L, l);
        v = {6'h00, h[1:0], l};
    endtask

    task automatic wait_req(input bit a, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
            if (n > 1100) begin
                chk(16'h0000, 16'h0001);
                end_sim;
            end
        end while ((a ? req_a : req_p) !== 1'b1);
    endtask

    task automatic t_reset;
        logic [7:0] d;
        rd(`CT_OFS_CTL0, d);
        chk(16'(d), 16'h0000);
        rd(`CT_OFS_CTL1, d);
        chk(16'(d), 16'h0000);
        rd(3'h6, d);
        chk(16'(d), 16'h0000);
        // Reset selects compare mode, so the pin is already driven.
        chk({13'h0000, en_o, out_o, outn_o}, 16'h0005);
        $display("test reset done");
    endtask

    task automatic t_buf;
        logic [7:0] d;
        wr(`CT_OFS_CMPA_L, 8'h34);
        wr(`CT_OFS_CMPA_H, 8'h02);
        wr(`CT_OFS_CMPA_L, 8'h56);
        rd(`CT_OFS_CMPA_H, d);
        chk(16'(d), 16'h0002);
        rd(`CT_OFS_CMPA_L, d);
        chk(16'(d), 16'h0034);
        $display("test buffer done");
    endtask

    task automatic t_period;
        int n;
        logic [2:0] p;
        wr(`CT_OFS_CTL1, 8'h00);
        for (int i = 0; i < 3; i++) begin
            p = (i == 2) ? 3'h0 : 3'(i + 1);
            wr(`CT_OFS_CTL0, 8'h10);
            wr(`CT_OFS_CTL0, {5'h03, p});
            wait_req(1'b0, n);
            wait_req(1'b0, n);
            chk(16'(n), (p == 3'h0) ? 16'h0400 : 16'(p) * 16'h0080);
        end
        $display("test period done");
    endtask

    task automatic t_pause;
        logic [15:0] a, b;
        wr(`CT_OFS_CTL0, 8'h18);
        repeat (40) @(posedge clk_i);
        wr(`CT_OFS_CTL0, 8'h98);
        rd_cnt(a);
        wr(`CT_OFS_CNT_L, 8'hFF);
        wr(`CT_OFS_CNT_H, 8'h03);
        rd_cnt(b);
        chk(b, a);
        wr(`CT_OFS_CTL0, 8'h18);
        rd_cnt(b);
        chk(16'(b != a), 16'h0001);
        wr(`CT_OFS_CTL0, 8'h10);
        rd_cnt(a);
        repeat (20) @(posedge clk_i);
        rd_cnt(b);
        chk(b, a);
        wr(`CT_OFS_CTL0, 8'h18);
        rd_cnt(b);
        chk(16'(b < 16'h000A), 16'h0001);
        $display("test pause done");
    endtask

    task automatic t_cmp;
        int n;
        logic [7:0] cfg [5] = '{8'h39, 8'h19, 8'h21, 8'h01, 8'h3D};
        logic [1:0] ex [5] = '{2'b10, 2'b10, 2'b01, 2'b00, 2'b01};
        wr(`CT_OFS_CMPA_L, 8'h20);
        wr(`CT_OFS_CMPA_H, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(`CT_OFS_CTL0, 8'h10);
            wr(`CT_OFS_CTL1, cfg[i]);
            wr(`CT_OFS_CTL0, 8'h18);
            repeat (3) @(posedge clk_i);
            #1 chk({13'h0000, en_o, out_o, outn_o},
                   {13'h0000, 1'b1, ex[i][1], ~ex[i][1]});
            wait_req(1'b1, n);
            @(posedge clk_i);
            #1 chk({14'h0000, out_o, outn_o},
                   {14'h0000, ex[i][0], ~ex[i][0]});
            if (i == 0) begin
                wait_req(1'b1, n);
                // The pin check above used one cycle of this period.
                chk(16'(n) + 16'h0001, 16'h0020);
            end
        end
        $display("test compare done");
    endtask

    task automatic t_pwm;
        int n;
        for (int f = 0; f < 2; f++) begin
            wr(`CT_OFS_CTL0, 8'h10);
            wr(`CT_OFS_CTL1, 8'h88 | 8'(f << 4));
            wr(`CT_OFS_CTL0, 8'h19);
            repeat (3) @(posedge clk_i);
            #1 chk({14'h0000, en_o, out_o}, {14'h0000, 1'b1, 1'(f)});
        end
        wr(`CT_OFS_CTL0, 8'h10);
        wr(`CT_OFS_CTL1, 8'hA8);
        wr(`CT_OFS_CTL0, 8'h19);
        repeat (8) @(posedge clk_i);
        n = 0;
        repeat (256) begin
            @(posedge clk_i);
            #1 if (out_o === 1'b1) n++;
        end
        chk(16'(n), 16'h0040);
        wr(`CT_OFS_CTL0, 8'h10);
        wr(`CT_OFS_CTL1, 8'hC0);
        wr(`CT_OFS_CTL0, 8'h18);
        repeat (3) @(posedge clk_i);
        #1 chk(16'(en_o), 16'h0000);
        $display("test pwm done");
    endtask

    task automatic t_ext;
        logic [15:0] v;
        wr(`CT_OFS_CTL0, 8'h10);
        wr(`CT_OFS_CTL0, 8'h68);
        i_far.pulse(5);
        rd_cnt(v);
        chk(v, 16'h0005);
        wr(`CT_OFS_CTL0, 8'h70);
        wr(`CT_OFS_CTL0, 8'h78);
        i_far.pulse(3);
        rd_cnt(v);
        chk(v, 16'h0003);
        $display("test count pin done");
    endtask

    // Free-running prescalers and the asynchronous clocks leave a
    // phase uncertainty, so each count may lie in a window of three.
    task automatic t_clk;
        logic [15:0] v;
        logic [7:0]  sel [5] = '{8'h08, 8'h28, 8'h38, 8'h48, 8'h58};
        int          cyc [5] = '{400, 1408, 1408, 2500, 2500};
        int          lo [5] = '{99, 19, 4, 2, 2};
        for (int i = 0; i < 5; i++) begin
            wr(`CT_OFS_CTL0, 8'h10);
            wr(`CT_OFS_CTL0, sel[i]);
            repeat (cyc[i]) @(posedge clk_i);
            rd_cnt(v);
            chk(16'(v - 16'(lo[i]) <= 16'h0002), 16'h0001);
        end
        $display("test clock select done");
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_buf;
        t_period;
        t_pause;
        t_cmp;
        t_pwm;
        t_ext;
        t_clk;
        end_sim;
    end
endmodule
